// *** verilog/cfg_regs_pkg.sv ***
// Constants and helpers for the command and status configuration registers
package cfg_regs_pkg;

  // Configuration dword that holds command (low half) and status (high half)
  localparam logic [5:0] CMD_STATUS_DWORD = 6'h01;

  // Command bit positions
  localparam int CMD_IO_BIT = 0;
  localparam int CMD_MEM_BIT = 1;
  localparam int CMD_MASTER_BIT = 2;
  localparam int CMD_SPECIAL_BIT = 3;
  localparam int CMD_MWI_BIT = 4;
  localparam int CMD_VGA_BIT = 5;
  localparam int CMD_PERR_BIT = 6;
  localparam int CMD_STEP_BIT = 7;
  localparam int CMD_SERR_BIT = 8;
  localparam int CMD_FBB_BIT = 9;

  // Writable command bits: 1, 2, 4, 6 and 8
  localparam logic [15:0] CMD_WR_MASK = 16'h0156;
  localparam logic [15:0] CMD_RESET = 16'h0000;

  // Status bit positions
  localparam int STS_CAP_BIT = 4;
  localparam int STS_66MHZ_BIT = 5;
  localparam int STS_FBB_BIT = 7;
  localparam int STS_SSE_BIT = 14;
  localparam int STS_DPE_BIT = 15;

  // Fixed status image: capability list set, medium select timing 01b
  localparam logic [15:0] STS_FIXED = 16'h0210;
  localparam logic STS_FLAG_RESET = 1'b0;

  // Byte enables of a 16-bit half expanded to a bit mask
  function automatic logic [15:0] lane_mask(input logic [1:0] be);
    lane_mask = {{8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask

endpackage : cfg_regs_pkg

// *** verilog/cfg_wr_if.sv ***
// Configuration write strobe shared by the register units
`timescale 1ns/1ps
interface cfg_wr_if;
  logic wr;
  logic [3:0] be;
  logic [31:0] data;

  modport src (
    output wr,
    output be,
    output data
  );
  modport dst (
    input wr,
    input be,
    input data
  );
endinterface : cfg_wr_if

// *** verilog/cmd_reg_unit.sv ***
// Command register storage with per-byte writes of the writable bits
`timescale 1ns/1ps
module cmd_reg_unit
  import cfg_regs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  cfg_wr_if.dst wr,
  output logic [15:0] cmd
);

  typedef struct packed {
    logic [15:0] cmd;
  } cmd_state_t;

  cmd_state_t cur;
  cmd_state_t next_cur;

  always_comb begin
    logic [15:0] mask;
    mask = 16'h0000;
    next_cur = cur;
    if (wr.wr) begin
      // Read-only and reserved bits never take a write
      mask = lane_mask(wr.be[1:0]) & CMD_WR_MASK;
      next_cur.cmd = (cur.cmd & ~mask) | (wr.data[15:0] & mask);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cur.cmd <= CMD_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  assign cmd = cur.cmd;

endmodule : cmd_reg_unit

// *** verilog/status_flag_unit.sv ***
// Sticky status error flags, cleared by writing one
`timescale 1ns/1ps
module status_flag_unit
  import cfg_regs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  cfg_wr_if.dst wr,
  input wire logic parity_seen,
  input wire logic serr_active,
  output logic dpe_flag,
  output logic sse_flag
);

  typedef struct packed {
    logic dpe;
    logic sse;
  } sts_state_t;

  sts_state_t cur;
  sts_state_t next_cur;

  always_comb begin
    logic [15:0] clr;
    clr = 16'h0000;
    if (wr.wr) begin
      clr = lane_mask(wr.be[3:2]) & wr.data[31:16];
    end
    // Set wins over a same-cycle clear so no event is lost
    next_cur.dpe = parity_seen | (cur.dpe & ~clr[STS_DPE_BIT]);
    next_cur.sse = serr_active | (cur.sse & ~clr[STS_SSE_BIT]);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cur.dpe <= STS_FLAG_RESET;
      cur.sse <= STS_FLAG_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  assign dpe_flag = cur.dpe;
  assign sse_flag = cur.sse;

endmodule : status_flag_unit

// *** verilog/pci_cmd_status_regs.sv ***
// Command and status configuration registers with the gates they control
`timescale 1ns/1ps
module pci_cmd_status_regs
  import cfg_regs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cfg_access,
  input wire logic cfg_write,
  input wire logic [5:0] cfg_dword,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_ack,
  input wire logic mem_decode_hit,
  output logic mem_claim,
  input wire logic bus_master_req,
  output logic master_start,
  input wire logic mwi_req,
  output logic use_mwi,
  input wire logic parity_err_detect,
  input wire logic system_err_detect,
  output logic perr_n_out,
  output logic perr_n_oe,
  output logic serr_n_out,
  output logic serr_n_oe,
  output logic mem_space_en,
  output logic bus_master_en,
  output logic mwi_en,
  output logic perr_resp_en,
  output logic serr_en
);

  typedef struct packed {
    logic [31:0] rdata;
    logic ack;
    logic mem_claim;
    logic master_start;
    logic use_mwi;
    logic perr_n_out;
    logic perr_n_oe;
    logic serr_n_out;
    logic serr_n_oe;
  } top_state_t;

  top_state_t cur;
  top_state_t next_cur;

  logic [15:0] cmd;
  logic dpe_flag;
  logic sse_flag;
  logic hit;
  logic [15:0] cmd_image;
  logic [15:0] sts_image;

  cfg_wr_if cw();

  assign hit = cfg_access && (cfg_dword == CMD_STATUS_DWORD);
  assign cw.wr = hit && cfg_write;
  assign cw.be = cfg_be;
  assign cw.data = cfg_wdata;

  cmd_reg_unit u_cmd (
    .ref_clk (ref_clk),
    .rst (rst),
    .wr (cw),
    .cmd (cmd)
  );

  status_flag_unit u_sts (
    .ref_clk (ref_clk),
    .rst (rst),
    .wr (cw),
    .parity_seen (parity_err_detect),
    .serr_active (cur.serr_n_oe),
    .dpe_flag (dpe_flag),
    .sse_flag (sse_flag)
  );

  // Only writable bits can ever be set in storage
  assign cmd_image = cmd & CMD_WR_MASK;

  always_comb begin
    sts_image = STS_FIXED;
    sts_image[STS_DPE_BIT] = dpe_flag;
    sts_image[STS_SSE_BIT] = sse_flag;
  end

  always_comb begin
    next_cur = cur;
    next_cur.ack = cfg_access;
    if (cfg_access && !cfg_write) begin
      // Other dwords belong to neighbouring registers; they read zero here
      next_cur.rdata = hit ? {sts_image, cmd_image} : 32'h0000_0000;
    end
    next_cur.mem_claim = mem_decode_hit && cmd[CMD_MEM_BIT];
    next_cur.master_start = bus_master_req && cmd[CMD_MASTER_BIT];
    next_cur.use_mwi = mwi_req && cmd[CMD_MWI_BIT];
    // Parity pin: one cycle low, then one cycle driven high before release
    if (parity_err_detect && cmd[CMD_PERR_BIT]) begin
      next_cur.perr_n_oe = 1'b1;
      next_cur.perr_n_out = 1'b0;
    end else if (cur.perr_n_oe && !cur.perr_n_out) begin
      next_cur.perr_n_oe = 1'b1;
      next_cur.perr_n_out = 1'b1;
    end else begin
      next_cur.perr_n_oe = 1'b0;
      next_cur.perr_n_out = 1'b1;
    end
    // Open-drain system error: only ever pulled low, never driven high
    next_cur.serr_n_oe = system_err_detect && cmd[CMD_SERR_BIT];
    next_cur.serr_n_out = !(system_err_detect && cmd[CMD_SERR_BIT]);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cur.rdata <= 32'h0000_0000;
      cur.ack <= 1'b0;
      cur.mem_claim <= 1'b0;
      cur.master_start <= 1'b0;
      cur.use_mwi <= 1'b0;
      cur.perr_n_out <= 1'b1;
      cur.perr_n_oe <= 1'b0;
      cur.serr_n_out <= 1'b1;
      cur.serr_n_oe <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  assign cfg_rdata = cur.rdata;
  assign cfg_ack = cur.ack;
  assign mem_claim = cur.mem_claim;
  assign master_start = cur.master_start;
  assign use_mwi = cur.use_mwi;
  assign perr_n_out = cur.perr_n_out;
  assign perr_n_oe = cur.perr_n_oe;
  assign serr_n_out = cur.serr_n_out;
  assign serr_n_oe = cur.serr_n_oe;
  assign mem_space_en = cmd[CMD_MEM_BIT];
  assign bus_master_en = cmd[CMD_MASTER_BIT];
  assign mwi_en = cmd[CMD_MWI_BIT];
  assign perr_resp_en = cmd[CMD_PERR_BIT];
  assign serr_en = cmd[CMD_SERR_BIT];

  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_io_bit_zero: assert property (
    cfg_ack |-> !cfg_rdata[CMD_IO_BIT])
    else $error("I/O space bit read as one");

  a_mem_claim_gate: assert property (
    mem_decode_hit |=> (mem_claim == $past(mem_space_en)))
    else $error("Memory claim does not follow memory space enable");

  a_master_gate: assert property (
    master_start |-> $past(bus_master_req) && $past(bus_master_en))
    else $error("Initiator start without bus master enable");

  a_master_follows: assert property (
    bus_master_req && bus_master_en |=> master_start)
    else $error("Enabled initiator request was dropped");

  a_fixed_cmd_zero: assert property (
    cfg_ack |-> !cfg_rdata[CMD_SPECIAL_BIT] && !cfg_rdata[CMD_VGA_BIT]
      && !cfg_rdata[CMD_STEP_BIT])
    else $error("Fixed command bit read as one");

  a_mwi_gate: assert property (
    mwi_req |=> (use_mwi == $past(mwi_en)))
    else $error("Invalidate command use does not follow its enable");

  a_perr_silent: assert property (
    perr_n_oe && !perr_n_out |-> $past(parity_err_detect) && $past(perr_resp_en))
    else $error("Parity pin driven low without response enable");

  a_perr_release: assert property (
    perr_n_oe && !perr_n_out && !(parity_err_detect && perr_resp_en) |=> perr_n_oe
      && perr_n_out)
    else $error("Parity pin not driven high after assertion");

  a_dpe_sticky: assert property (
    parity_err_detect |=> dpe_flag)
    else $error("Detected parity flag did not set");

  a_serr_gate: assert property (
    serr_n_oe |-> $past(system_err_detect) && $past(serr_en) && !serr_n_out)
    else $error("System error pin asserted while disabled");

  a_fbb_zero: assert property (
    cfg_ack |-> !cfg_rdata[CMD_FBB_BIT] && !cfg_rdata[16 + STS_FBB_BIT])
    else $error("Fast back-to-back bit read as one");

  a_reserved_zero: assert property (
    cfg_ack |-> cfg_rdata[15:10] == 6'h00 && cfg_rdata[19:16] == 4'h0
      && !cfg_rdata[22])
    else $error("Reserved field read as nonzero");

  a_cap_bits: assert property (
    $past(hit) && !$past(cfg_write) |-> cfg_rdata[16 + STS_CAP_BIT]
      && !cfg_rdata[16 + STS_66MHZ_BIT])
    else $error("Capability or speed bit wrong");

  a_sse_set: assert property (
    serr_n_oe |=> sse_flag ##1 (sse_flag || $past(cw.wr)))
    else $error("Signaled system error flag did not set");

  a_cmd_reset_state: assert property (
    $rose(mem_space_en) |-> $past(cw.wr) && $past(cfg_be[0]) && $past(cfg_wdata[CMD_MEM_BIT]))
    else $error("Memory enable rose without a write");

  // Storage checks catch a broken write mask even when no read follows
  a_io_store_zero: assert property (
    !cmd[CMD_IO_BIT])
    else $error("I/O space bit stored as one");

  a_mem_write: assert property (
    cw.wr && cfg_be[0] |=> mem_space_en == $past(cfg_wdata[CMD_MEM_BIT]))
    else $error("Memory space enable did not take the write");

  a_mem_hold: assert property (
    !cw.wr |=> $stable(mem_space_en))
    else $error("Memory space enable changed without a write");

  a_mem_claim_off: assert property (
    !mem_space_en |=> !mem_claim)
    else $error("Memory claim while memory space disabled");

  a_master_write: assert property (
    cw.wr && cfg_be[0] |=> bus_master_en == $past(cfg_wdata[CMD_MASTER_BIT]))
    else $error("Bus master enable did not take the write");

  a_master_hold: assert property (
    !cw.wr |=> $stable(bus_master_en))
    else $error("Bus master enable changed without a write");

  a_fixed_store: assert property (
    !cmd[CMD_SPECIAL_BIT] && !cmd[CMD_VGA_BIT] && !cmd[CMD_STEP_BIT])
    else $error("Fixed command bit stored as one");

  a_mwi_write: assert property (
    cw.wr && cfg_be[0] |=> mwi_en == $past(cfg_wdata[CMD_MWI_BIT]))
    else $error("Invalidate enable did not take the write");

  a_mwi_hold: assert property (
    !cw.wr |=> $stable(mwi_en))
    else $error("Invalidate enable changed without a write");

  a_perr_write: assert property (
    cw.wr && cfg_be[0] |=> perr_resp_en == $past(cfg_wdata[CMD_PERR_BIT]))
    else $error("Parity response enable did not take the write");

  a_perr_quiet: assert property (
    !perr_resp_en && !(perr_n_oe && !perr_n_out) |=> !perr_n_oe)
    else $error("Parity pin driven while response disabled");

  a_perr_high_end: assert property (
    perr_n_oe && perr_n_out && !(parity_err_detect && perr_resp_en) |=> !perr_n_oe)
    else $error("Parity pin not released after driving high");

  a_perr_idle: assert property (
    !perr_n_oe |-> perr_n_out)
    else $error("Parity pin output low while released");

  a_dpe_hold: assert property (
    dpe_flag && !(cw.wr && cfg_be[3] && cfg_wdata[16 + STS_DPE_BIT]) |=> dpe_flag)
    else $error("Detected parity flag dropped without a clear");

  a_dpe_clear: assert property (
    cw.wr && cfg_be[3] && cfg_wdata[16 + STS_DPE_BIT] && !parity_err_detect |=> !dpe_flag)
    else $error("Detected parity flag not cleared by a write of one");

  a_dpe_cause: assert property (
    $rose(dpe_flag) |-> $past(parity_err_detect))
    else $error("Detected parity flag set without a parity error");

  a_serr_write: assert property (
    cw.wr && cfg_be[1] |=> serr_en == $past(cfg_wdata[CMD_SERR_BIT]))
    else $error("System error enable did not take the write");

  a_serr_follows: assert property (
    system_err_detect && serr_en |=> serr_n_oe)
    else $error("Enabled system error was not signalled");

  a_serr_idle: assert property (
    !serr_n_oe |-> serr_n_out)
    else $error("System error output low while released");

  a_fbb_store: assert property (
    !cmd[CMD_FBB_BIT])
    else $error("Fast back-to-back bit stored as one");

  a_reserved_store: assert property (
    cmd[15:10] == 6'h00)
    else $error("Reserved command bits stored as nonzero");

  a_other_zero: assert property (
    $past(cfg_access) && !$past(cfg_write) && !$past(hit) |-> cfg_rdata == 32'h0000_0000)
    else $error("Read of another dword returned nonzero");

  a_sse_cause: assert property (
    $rose(sse_flag) |-> $past(serr_n_oe))
    else $error("Signaled system error flag set without the pin");

  a_sse_clear: assert property (
    cw.wr && cfg_be[3] && cfg_wdata[16 + STS_SSE_BIT] && !serr_n_oe |=> !sse_flag)
    else $error("Signaled system error flag not cleared by a write of one");

endmodule : pci_cmd_status_regs

// *** verif/cfg_host_model.sv ***
// Host bridge model issuing configuration cycles
`timescale 1ns/1ps
module cfg_host_model (
  input wire logic ref_clk,
  output logic cfg_access,
  output logic cfg_write,
  output logic [5:0] cfg_dword,
  output logic [3:0] cfg_be,
  output logic [31:0] cfg_wdata
);
  initial begin
    cfg_access = 1'b0;
    cfg_write = 1'b0;
    cfg_dword = 6'h00;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0;
  end

  // Called just after an edge; gap 0 keeps the next access back to back
  task automatic access(input logic w, input logic [5:0] d, input logic [3:0] be,
                        input logic [31:0] data, input int gap);
    cfg_access = 1'b1;
    cfg_write = w;
    cfg_dword = d;
    cfg_be = be;
    cfg_wdata = data;
    @(posedge ref_clk);
    #1;
    if (gap > 0) begin
      cfg_access = 1'b0;
      // Released lines carry junk so nothing leans on stale values
      cfg_write = ~w;
      cfg_dword = ~d;
      cfg_be = ~be;
      cfg_wdata = ~data;
      repeat (gap - 1) @(posedge ref_clk);
      if (gap > 1) #1;
    end
  endtask : access
endmodule : cfg_host_model

// *** verif/pci_cmd_status_regs_bench.sv ***
// Self-checking bench for the command and status registers
`timescale 1ns/1ps
module pci_cmd_status_regs_bench;
  logic ref_clk, rst, cfg_access, cfg_write, cfg_ack, mem_decode_hit, mem_claim;
  logic bus_master_req, master_start, mwi_req, use_mwi, parity_err_detect;
  logic system_err_detect, perr_n_out, perr_n_oe, serr_n_out, serr_n_oe;
  logic mem_space_en, bus_master_en, mwi_en, perr_resp_en, serr_en, dpe, sse;
  logic [5:0] cfg_dword;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, r;
  logic [15:0] cmd;
  logic [11:0] got_pins;
  logic [32:0] rd_q[$];
  logic [11:0] pin_q[$];
  int n_mismatch = 0;
  int checks = 0;
  integer seed = 20;
  int ps;

  cfg_host_model i_host (.ref_clk, .cfg_access, .cfg_write, .cfg_dword, .cfg_be, .cfg_wdata);
  pci_cmd_status_regs i_dut (.ref_clk, .rst, .cfg_access, .cfg_write, .cfg_dword, .cfg_be,
    .cfg_wdata, .cfg_rdata, .cfg_ack, .mem_decode_hit, .mem_claim, .bus_master_req,
    .master_start, .mwi_req, .use_mwi, .parity_err_detect, .system_err_detect, .perr_n_out,
    .perr_n_oe, .serr_n_out, .serr_n_oe, .mem_space_en, .bus_master_en, .mwi_en,
    .perr_resp_en, .serr_en);

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic fail(input string msg);
    n_mismatch++;
    $display("mismatch %0t %s", $time, msg);
  endtask : fail

  task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) fail($sformatf("read %h expected %h", got, exp));
  endtask : cmp_rd

  task automatic cmp_pins(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp) fail($sformatf("pins %b expected %b", got, exp));
  endtask : cmp_pins

  // Model updates before the access so a back-to-back read sees the write
  task automatic cfg(input logic w, input logic [3:0] be, input logic [31:0] d,
                     input logic [5:0] dw, input int gap);
    logic [15:0] m;
    m = {{8{be[1]}}, {8{be[0]}}} & 16'h0156;
    rd_q.push_back({!w, (dw == 6'h01) ? {dpe, sse, 14'h0210, cmd} : 32'h0});
    if (w && dw == 6'h01) begin
      cmd = (cmd & ~m) | (d[15:0] & m);
      dpe = dpe & !(be[3] & d[31]);
      sse = sse & !(be[3] & d[30]);
    end
    i_host.access(w, dw, be, d, gap);
  endtask : cfg

  // Last three cycles idle so the error pin walk ends between bursts
  task automatic burst(input int n);
    for (int k = 0; k < n; k++) begin
      r = (k >= n - 3) ? 32'h0 : $random(seed);
      mem_decode_hit = r[0];
      bus_master_req = r[1];
      mwi_req = r[2];
      parity_err_detect = r[3] && (k % 4 == 0);
      system_err_detect = r[4];
      @(posedge ref_clk);
      #1;
      if (parity_err_detect && cmd[6]) ps = 1;
      else if (ps == 1) ps = 2;
      else ps = 0;
      dpe = dpe | parity_err_detect;
      sse = sse | (system_err_detect & cmd[8]);
      pin_q.push_back({mem_decode_hit & cmd[1], bus_master_req & cmd[2], mwi_req & cmd[4],
        ps != 0, ps != 1, system_err_detect & cmd[8], !(system_err_detect & cmd[8]),
        cmd[1], cmd[2], cmd[4], cmd[6], cmd[8]});
    end
  endtask : burst

  always @(negedge ref_clk) begin
    if (cfg_ack === 1'b1) begin
      if (rd_q.size() == 0) fail("unexpected ack");
      else if (rd_q[0][32]) cmp_rd(cfg_rdata, rd_q[0][31:0]);
      if (rd_q.size() > 0) void'(rd_q.pop_front());
    end
    if (pin_q.size() > 0) begin
      got_pins = {mem_claim, master_start, use_mwi, perr_n_oe, perr_n_out, serr_n_oe,
        serr_n_out, mem_space_en, bus_master_en, mwi_en, perr_resp_en, serr_en};
      cmp_pins(got_pins, pin_q.pop_front());
    end
  end

  task automatic finish_test;
    if (rd_q.size() != 0) n_mismatch++;
    if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test

  initial begin
    repeat (5000) @(posedge ref_clk);
    n_mismatch++;
    finish_test();
  end

  initial begin
    rst = 1'b1;
    {mem_decode_hit, bus_master_req, mwi_req, parity_err_detect, system_err_detect} = 5'h00;
    {cmd, dpe, sse, ps} = '0;
    repeat (20) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    cfg(1'b0, 4'hF, 32'h0, 6'h01, 0);
    cfg(1'b1, 4'hF, 32'hFFFF_FFFF, 6'h01, 0);
    cfg(1'b0, 4'hF, 32'h0, 6'h00, 0);
    cfg(1'b0, 4'hF, 32'h0, 6'h01, 1);
    burst(12);
    for (int i = 0; i < 12; i++) begin
      r = $random(seed);
      cfg(1'b1, r[3:0], $random(seed), (r[5:4] == 2'h3) ? 6'h00 : 6'h01,
        int'(r[6]));
      cfg(1'b0, 4'hF, 32'h0, 6'h01, 1);
      burst(12);
    end
    // Let the last pin compare land before reset clears the enables
    @(posedge ref_clk);
    #1;
    // Second reset in mid-run must bring every enable and flag back to zero
    rst = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    {cmd, dpe, sse, ps} = '0;
    burst(4);
    cfg(1'b0, 4'hF, 32'h0, 6'h01, 2);
    finish_test();
  end
endmodule : pci_cmd_status_regs_bench
